// [hdl/pctf_regs.vh]
`ifndef PCTF_REGS_VH
`define PCTF_REGS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define PCTF_CFG_BASE        32'h00000000
`define PCTF_CNT_STRIDE      32'h00000100
`define PCTF_AK_OFF          8'h14
`define PCTF_WL_OFF          8'h18
`define PCTF_CTRL_ADDR       32'h00000F00
`define PCTF_CNT_ADDR        32'h00000F04
// ----------------------------------------
// Fields
// ----------------------------------------
`define PCTF_EN_BIT          31
`define PCTF_AK_W            3
`define PCTF_WL_W            5
`define PCTF_AK_RST          3'h0
`define PCTF_WL_RST          5'h0
`define PCTF_CTRL_PM_BIT     0
`define PCTF_CTRL_AKS_BIT    1
`define PCTF_CTRL_WLS_BIT    2
`define PCTF_CTRL_RST        3'h7
`endif

// [hdl/pctf_cfg_mem.v]
module pctf_cfg_mem #(
    parameter AW = 2,
    parameter DW = 9
) (
    input  wire          ref_clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // pctf_cfg_mem

// [hdl/pctf_filters.v]
// Local design decision: the APB register port.
`include "pctf_regs.vh"
module pctf_filters #(
    parameter       NCNT        = 4,
    parameter [2:0] AK_IMPL     = 3'h7
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [3:0]  evtValid,
    input  wire [7:0]  evtAddrKind,
    input  wire [19:0] evtWalkLevel,
    output reg  [3:0]  countInc
);
    // ----------------------------------------
    // Software controls and per-counter state
    // ----------------------------------------
    reg  [2:0]  ctrl;
    reg  [3:0]  akEn;
    reg  [11:0] akMap;
    reg  [3:0]  wlEn;
    reg  [19:0] wlMap;
    reg  [3:0]  cfgSeen;

    reg  [2:0]  slot;
    reg  [31:0] next_prdata;
    reg         next_err;
    reg  [3:0]  next_inc;
    reg  [3:0]  akOk;
    reg  [3:0]  wlOk;
    reg  [31:0] incTally;
    reg  [9:0]  memWr;
    wire [9:0]  memRd;

    wire        pmOn  = ctrl[`PCTF_CTRL_PM_BIT];
    wire        akOn  = pmOn & ctrl[`PCTF_CTRL_AKS_BIT];
    wire        wlOn  = pmOn & ctrl[`PCTF_CTRL_WLS_BIT];

    // ----------------------------------------
    // Decode and field helpers
    // ----------------------------------------
    // The window check keeps the control page out of the filter slots
    function slotHit;
        input [31:0] offs;
        input [7:0]  sel;
        begin
            slotHit = (offs[31:10] == 22'h000000) & (offs[7:0] == sel);
        end
    endfunction

    // Enable plus the kinds that are built; everything else is dropped here
    function [3:0] akField;
        input [31:0] wd;
        begin
            akField = {wd[`PCTF_EN_BIT], wd[2:0] & AK_IMPL};
        end
    endfunction

    function [5:0] wlField;
        input [31:0] wd;
        begin
            wlField = {wd[`PCTF_EN_BIT], wd[4:0]};
        end
    endfunction

    function [31:0] akWord;
        input       seen;
        input [9:0] word;
        begin
            if (seen) begin
                akWord = {word[9], 28'h0000000, word[8:6]};
            end else begin
                akWord = 32'h00000000;
            end
        end
    endfunction

    function [31:0] wlWord;
        input       seen;
        input [9:0] word;
        begin
            if (seen) begin
                wlWord = {word[5], 26'h0000000, word[4:0]};
            end else begin
                wlWord = 32'h00000000;
            end
        end
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire        acc   = psel & penable;
    wire [31:0] rel   = paddr - `PCTF_CFG_BASE;
    wire [1:0]  cnt   = rel[9:8];
    wire        isAk  = slotHit(rel, `PCTF_AK_OFF) & pmOn;
    wire        isWl  = slotHit(rel, `PCTF_WL_OFF) & pmOn;
    wire        isCtl = (paddr == `PCTF_CTRL_ADDR);
    wire        isCnt = (paddr == `PCTF_CNT_ADDR);
    wire        doWr  = acc & pwrite & pready;
    wire        akWr  = doWr & isAk & akOn;
    wire        wlWr  = doWr & isWl & wlOn;
    wire        anyInc = |next_inc;

    // ----------------------------------------
    // Slot codes
    // ----------------------------------------
    localparam [2:0] SLOT_NONE = 3'h0;
    localparam [2:0] SLOT_AK   = 3'h1;
    localparam [2:0] SLOT_WL   = 3'h2;
    localparam [2:0] SLOT_CTL  = 3'h3;
    localparam [2:0] SLOT_CNT  = 3'h4;

    // ----------------------------------------
    // Per-counter configuration memory
    // ----------------------------------------
    // The stored word merges the new half with the untouched half of the same counter
    always @* begin
        memWr = {akEn[cnt], akMap[cnt*3 +: 3], wlEn[cnt], wlMap[cnt*5 +: 5]};
        if (akWr) begin
            memWr[9:6] = akField(pwdata);
        end else if (wlWr) begin
            memWr[5:0] = wlField(pwdata);
        end
    end

    // Read word is loaded while the setup cycle stands, ready for the answer edge
    pctf_cfg_mem #(.AW(2), .DW(10)) uMem (
        .ref_clk (ref_clk),
        .we      (akWr | wlWr),
        .waddr   (cnt),
        .wdata   (memWr),
        .raddr   (cnt),
        .rdata   (memRd)
    );

    // ----------------------------------------
    // Match helpers
    // ----------------------------------------
    function akHit;
        input [2:0] map;
        input [1:0] kind;
        begin
            // 00 untranslated, 01 translation, 10 translated, 11 never
            akHit = (kind == 2'h3) ? 1'b0 : map[kind];
        end
    endfunction

    function wlHit;
        input [4:0] map;
        input [4:0] lvl;
        begin
            wlHit = |(map & lvl);
        end
    endfunction

    function akPass;
        input       on;
        input [2:0] map;
        input [1:0] kind;
        begin
            // A filter left off lets every event through
            if (on) begin
                akPass = akHit(map, kind);
            end else begin
                akPass = 1'b1;
            end
        end
    endfunction

    function wlPass;
        input       on;
        input [4:0] map;
        input [4:0] lvl;
        begin
            // A filter left off lets every event through
            if (on) begin
                wlPass = wlHit(map, lvl);
            end else begin
                wlPass = 1'b1;
            end
        end
    endfunction

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    integer i;

    // Control stays writable with monitoring off, so software can turn it back on
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl <= `PCTF_CTRL_RST;
        end else if (doWr & isCtl) begin
            ctrl <= pwdata[2:0];
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            akEn  <= 4'h0;
            akMap <= 12'h000;
        end else if (akWr) begin
            {akEn[cnt], akMap[cnt*3 +: 3]} <= akField(pwdata);
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            wlEn  <= 4'h0;
            wlMap <= 20'h00000;
        end else if (wlWr) begin
            {wlEn[cnt], wlMap[cnt*5 +: 5]} <= wlField(pwdata);
        end
    end

    // Reset cannot sweep the memory, so unwritten counters read as zero
    always @(posedge ref_clk) begin
        if (rst) begin
            cfgSeen <= 4'h0;
        end else if (akWr | wlWr) begin
            cfgSeen[cnt] <= 1'b1;
        end
    end

    // ----------------------------------------
    // APB read and answer
    // ----------------------------------------
    always @* begin
        slot = SLOT_NONE;
        if (isAk) begin
            slot = SLOT_AK;
        end else if (isWl) begin
            slot = SLOT_WL;
        end else if (isCtl) begin
            slot = SLOT_CTL;
        end else if (isCnt) begin
            slot = SLOT_CNT;
        end
    end

    // Unsupported filters read zero without error; absent ones answer with an error
    always @* begin
        next_prdata = 32'h00000000;
        next_err    = 1'b0;
        case (slot)
            SLOT_AK: begin
                if (akOn) begin
                    next_prdata = akWord(cfgSeen[cnt], memRd);
                end
            end
            SLOT_WL: begin
                if (wlOn) begin
                    next_prdata = wlWord(cfgSeen[cnt], memRd);
                end
            end
            SLOT_CTL: begin
                next_prdata = {29'h00000000, ctrl};
            end
            SLOT_CNT: begin
                next_prdata = incTally;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // Answer comes one cycle into the access phase so the read mux is registered
    always @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            if (acc & ~pready) begin
                pready  <= 1'b1;
                prdata  <= pwrite ? 32'h00000000 : next_prdata;
                pslverr <= next_err;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Event qualification
    // ----------------------------------------
    always @* begin
        akOk = 4'h0;
        wlOk = 4'h0;
        for (i = 0; i < NCNT; i = i + 1) begin
            akOk[i] = akPass(akOn & akEn[i], akMap[i*3 +: 3], evtAddrKind[i*2 +: 2]);
            wlOk[i] = wlPass(wlOn & wlEn[i], wlMap[i*5 +: 5], evtWalkLevel[i*5 +: 5]);
        end
    end

    // Monitoring off stops every counter whatever the filters hold
    always @* begin
        next_inc = 4'h0;
        if (pmOn) begin
            next_inc = evtValid & akOk & wlOk;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            countInc <= 4'h0;
        end else begin
            countInc <= next_inc;
        end
    end

    // Tally wraps silently; it is a debug aid, not an architectural counter
    always @(posedge ref_clk) begin
        if (rst) begin
            incTally <= 32'h00000000;
        end else if (anyInc) begin
            incTally <= incTally + 32'h00000001;
        end
    end
endmodule // pctf_filters

// [dv/pctf_filters_chk.sv]
// ------------------------------
// Port checks
// ------------------------------
module pctf_chk #(
    parameter [2:0] AK_IMPL = 3'h7
) (
    input logic        ref_clk,
    input logic        rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [3:0]  evtValid,
    input logic [3:0]  countInc
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    rdy_time_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered in time");
    rdy_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("answer without access");
    err_rdy_a: assert property (pslverr |-> pready)
        else $error("error flag outside answer");
    kind_rsvd_a: assert property (pready && !pwrite && paddr[7:0] == 8'h14 |->
        prdata[30:3] == 28'h0) else $error("kind reserved bits set");
    kind_impl_a: assert property (pready && !pwrite && paddr[7:0] == 8'h14 |->
        (prdata[2:0] & ~AK_IMPL) == 3'h0) else $error("unbuilt kind bit set");
    level_rsvd_a: assert property (pready && !pwrite && paddr[7:0] == 8'h18 |->
        prdata[30:5] == 26'h0) else $error("level reserved bits set");
    inc_cause_a: assert property ((countInc & ~$past(evtValid)) == 4'h0)
        else $error("increment without event");
    cover property (pready && pwrite);
    cover property (pready && pslverr);
    cover property (countInc != 4'h0);
endmodule // pctf_chk

bind pctf_filters pctf_chk #(.AK_IMPL(AK_IMPL)) u_chk (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evtValid(evtValid), .countInc(countInc));

// [dv/pctf_filters_tb.sv]
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin numErrors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
// ------------------------------
// Bench
// ------------------------------
module pctf_filters_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [3:0]  evtValid = 0, countInc;
    logic [7:0]  evtAddrKind = 0;
    logic [19:0] evtWalkLevel = 0;
    int          numErrors = 0, checksDone = 0;
    pctf_filters #(.AK_IMPL(3'h5)) DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evtValid(evtValid), .evtAddrKind(evtAddrKind),
        .evtWalkLevel(evtWalkLevel), .countInc(countInc));
    initial forever #25 ref_clk = ~ref_clk;
    task finalReport;
        $display("checks %0d errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        n = 0;
        // Sampled at the edge, before the slave's own updates land
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin numErrors++; finalReport(); end
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task ev(input int c, input int k, input int l, input logic x);
        @(posedge ref_clk);
        evtValid <= 4'h1 << c; evtAddrKind <= {4{k[1:0]}}; evtWalkLevel <= {4{5'h01 << l}};
        @(posedge ref_clk) evtValid <= 4'h0;
        @(negedge ref_clk);
        `CHK("countInc", {3'h0, x} << c, countInc)
    endtask
    task t_reset;
        apb(1'b0, 32'hF00, 32'h0); `CHK("ctrl", 32'h7, rd)
        for (int c = 0; c < 4; c++) begin
            apb(1'b0, 32'h100 * c + 32'h14, 32'h0); `CHK("kindRst", 32'h0, rd)
            apb(1'b0, 32'h100 * c + 32'h18, 32'h0); `CHK("levelRst", 32'h0, rd)
        end
        $display("reset test done");
    endtask
    task t_filter;
        for (int b = 0; b < 3; b++) begin
            apb(1'b1, 32'h14, 32'h80000000 | (32'h1 << b));
            for (int k = 0; k < 4; k++) ev(0, k, 0, k == b && b != 1);
        end
        for (int b = 0; b < 5; b++) begin
            apb(1'b1, 32'h118, 32'h80000000 | (32'h1 << b));
            for (int l = 0; l < 5; l++) ev(1, 0, l, l == b);
        end
        ev(2, 3, 4, 1'b1);
        apb(1'b1, 32'h18, 32'h80000001);
        ev(0, 2, 1, 1'b0);
        ev(0, 2, 0, 1'b1);
        ev(0, 0, 0, 1'b0);
        $display("filter test done");
    endtask
    task t_map;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 32'h100 * c + 32'h14, 32'hFFFFFFFF);
            apb(1'b1, 32'h100 * c + 32'h18, 32'hFFFFFFFF);
            apb(1'b0, 32'h100 * c + 32'h14, 32'h0); `CHK("kind", 32'h80000005, rd)
            apb(1'b0, 32'h100 * c + 32'h18, 32'h0); `CHK("level", 32'h8000001F, rd)
        end
        apb(1'b0, 32'h1C, 32'h0); `CHK("unmapped", 1'b1, er)
        $display("map test done");
    endtask
    task t_support;
        apb(1'b1, 32'hF00, 32'h5);
        apb(1'b1, 32'h314, 32'h80000001);
        apb(1'b0, 32'h14, 32'h0); `CHK("kindOff", 32'h0, rd)
        ev(0, 1, 0, 1'b1);
        apb(1'b1, 32'hF00, 32'h3);
        apb(1'b0, 32'h18, 32'h0); `CHK("levelOff", 32'h0, rd)
        apb(1'b1, 32'hF00, 32'h0);
        apb(1'b0, 32'h14, 32'h0); `CHK("pmOff", 1'b1, er)
        apb(1'b1, 32'hF00, 32'h7);
        apb(1'b0, 32'h314, 32'h0); `CHK("kindKept", 32'h80000005, rd)
        $display("support test done");
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_filter;
        t_map;
        t_support;
        finalReport;
    end
endmodule // pctf_filters_tb
